//--- esm_host_model.sv
// host master model issuing byte accesses and commands to the map
`timescale 1ns/100ps
module esm_host_model import esm_pkg::*; (
   input wire logic sys_clk, // system clock
   input wire logic [7:0] rdata, // read byte from the device
   input wire logic rd_valid, // read byte qualifier
   output esm_req_t req // requests toward the device
);
   initial req = '0;

   // address flipped on release so a stale value never looks current
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge sys_clk);
      req.rd <= 1'b0;
      req.addr <= ~a;
      #1 d = (rd_valid === 1'b1) ? rdata : 8'hXX;
   endtask

   // callers keep writes off reserved addresses
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= v;
      @(posedge sys_clk);
      req.wr <= 1'b0;
      req.addr <= ~a;
      req.wdata <= ~v;
   endtask

   // copy after shadow writes, recall before verifying reads
   task automatic cmd(input esm_cmd_t op, input logic [7:0] a);
      @(posedge sys_clk);
      req.start <= 1'b1;
      req.op <= op;
      req.addr <= a;
      @(posedge sys_clk);
      req.start <= 1'b0;
      req.addr <= ~a;
   endtask

   // ends a read command; both pair bytes are read before it
   task automatic done();
      @(posedge sys_clk);
      req.done <= 1'b1;
      @(posedge sys_clk);
      req.done <= 1'b0;
   endtask
endmodule

//--- esm_nv_access.sv
// register map, shadow ram and eeprom copy/recall/lock control
// Functional notes
// - a locked block refuses every write; only a factory erase unlocks it
// - reads of a block behave the same locked or unlocked
// - busy flag bit 7 reads 1 during copy; eeprom writes ignored then
// - lock command ignored unless lock-arm bit 6 is set by writing 1
// - lock must be the next command; any other command clears arm
// - arm clears when a lock finishes and reads 0 after reset
// - bit 1 reads 1 when parameter block 60h..80h is locked
// - bit 0 reads 1 when user block 20h..2Fh is locked
// - one linear byte space of 256 addresses holds everything
// - reserved addresses read FFh
// - 16-bit registers: high byte even address, low byte odd
// - high byte read latches low byte until the read command ends
// - read/write touch shadow; copy moves to cells, recall back
// - block inaccessible until copy finishes; host waits copy time
// - charge and aging saved when relative capacity crosses 4 percent
// - charge, aging, cycle count saved while active, recalled at power-up
// - parameter block: control first, slave address last, params between
// - factory gain readable, not writable, at fixed pair
`timescale 1ns/100ps
module esm_nv_access_top import esm_pkg::*; #(
   parameter int EEC_TIME_NS = 10000000,
   parameter logic [15:0] FACTORY_GAIN = 16'h0400
) (
   input wire logic sys_clk, // 40 MHz system clock
   input wire logic rstn, // asynchronous reset, active low
   input wire esm_req_t req, // byte access and command requests
   input wire esm_meas_t meas, // live measurement values
   input wire esm_upd_t upd, // gauge core register updates
   input wire logic factory_erase, // clears cells and lock flags
   output logic [7:0] rdata, // read byte, registered
   output logic rd_valid, // pulse with rdata
   output esm_cfg_t cfg, // writable registers to the core
   output logic [PARAM_BYTES-1:0][7:0] param_shadow, // parameter block
   output logic busy, // copy or lock in progress
   output logic scmd_valid, // pulse on command-port write
   output logic [7:0] scmd_byte // byte written to the command port
);
   localparam int EEC_CYC_RAW =
      (EEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EEC_CYC = (EEC_CYC_RAW < 1) ? 1 : EEC_CYC_RAW;
   localparam int TIMER_W = $clog2(EEC_CYC + 1);

   typedef struct packed {
      esm_state_t state;
      logic [TIMER_W-1:0] timer;
      logic blk_param;
      logic arm;
      logic lat_vld;
      logic [7:0] lat_addr;
      logic [7:0] lat_lo;
      logic [7:0] rdata;
      logic rd_valid;
      esm_cfg_t cfg;
      logic [5:0] remaining_active_relative_capacity_step;
      logic remaining_active_relative_capacity_seen;
      logic scmd_valid;
      logic [7:0] scmd_byte;
      logic [USER_BYTES-1:0][7:0] user;
      logic [PARAM_BYTES-1:0][7:0] param;
   } esm_st_t;

   // cells survive reset; only a factory erase touches them wholesale
   typedef struct packed {
      logic ulock;
      logic plock;
      logic [USER_BYTES-1:0][7:0] user;
      logic [PARAM_BYTES-1:0][7:0] param;
      logic [15:0] accumulated_charge;
      logic [7:0] age;
      logic [7:0] cyc;
   } esm_nv_t;

   esm_st_t st_r, st_nxt;
   esm_nv_t nv_r, nv_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   function automatic logic in_user(input logic [7:0] a);
      return (a >= USER_LO) && (a <= USER_HI);
   endfunction

   function automatic logic in_param(input logic [7:0] a);
      return (a >= PARAM_LO) && (a <= PARAM_HI);
   endfunction

   function automatic logic pair_hi(input logic [7:0] a);
      return a inside {OFF_REMAINING_ACTIVE_ABSOLUTE_CAPACITY, OFF_REMAINING_STANDBY_ABSOLUTE_CAPACITY, OFF_AVGI, OFF_TEMP, OFF_V1,
         OFF_CUR, OFF_ACR, OFF_ACRF, OFF_FULL, OFF_AE, OFF_SE, OFF_V2,
         OFF_FGAIN};
   endfunction

   function automatic logic [3:0] uidx(input logic [7:0] a);
      return 4'(a - USER_LO);
   endfunction

   function automatic logic [5:0] pidx(input logic [7:0] a);
      return 6'(a - PARAM_LO);
   endfunction

   // live byte at an address, before the pair latch is applied
   function automatic logic [7:0] raw_byte(input logic [7:0] a);
      logic [7:0] v;
      v = RSVD_READ;
      case (a)
         OFF_PROT: v = st_r.cfg.protection;
         OFF_STAT: v = st_r.cfg.status;
         OFF_REMAINING_ACTIVE_ABSOLUTE_CAPACITY: v = meas.remaining_active_absolute_capacity[15:8];
         OFF_REMAINING_ACTIVE_ABSOLUTE_CAPACITY + 8'h01: v = meas.remaining_active_absolute_capacity[7:0];
         OFF_REMAINING_STANDBY_ABSOLUTE_CAPACITY: v = meas.remaining_standby_absolute_capacity[15:8];
         OFF_REMAINING_STANDBY_ABSOLUTE_CAPACITY + 8'h01: v = meas.remaining_standby_absolute_capacity[7:0];
         OFF_REMAINING_ACTIVE_RELATIVE_CAPACITY: v = meas.remaining_active_relative_capacity;
         OFF_REMAINING_STANDBY_RELATIVE_CAPACITY: v = meas.remaining_standby_relative_capacity;
         OFF_AVGI: v = meas.avg_cur[15:8];
         OFF_AVGI + 8'h01: v = meas.avg_cur[7:0];
         OFF_TEMP: v = meas.temp[15:8];
         OFF_TEMP + 8'h01: v = meas.temp[7:0];
         OFF_V1: v = meas.v1[15:8];
         OFF_V1 + 8'h01: v = meas.v1[7:0];
         OFF_CUR: v = meas.cur[15:8];
         OFF_CUR + 8'h01: v = meas.cur[7:0];
         OFF_ACR: v = st_r.cfg.accumulated_charge[15:8];
         OFF_ACR + 8'h01: v = st_r.cfg.accumulated_charge[7:0];
         OFF_ACRF: v = meas.acr_frac[15:8];
         OFF_ACRF + 8'h01: v = meas.acr_frac[7:0];
         OFF_AGE: v = st_r.cfg.age;
         OFF_SFR: v = st_r.cfg.special;
         OFF_FULL: v = meas.full[15:8];
         OFF_FULL + 8'h01: v = meas.full[7:0];
         OFF_AE: v = meas.aempty[15:8];
         OFF_AE + 8'h01: v = meas.aempty[7:0];
         OFF_SE: v = meas.sempty[15:8];
         OFF_SE + 8'h01: v = meas.sempty[7:0];
         OFF_V2: v = meas.v2[15:8];
         OFF_V2 + 8'h01: v = meas.v2[7:0];
         OFF_CYC: v = st_r.cfg.cycle;
         OFF_NVC: begin
            v = 8'h00;
            v[NVC_BUSY_BIT] = (st_r.state == ST_COPY);
            v[NVC_ARM_BIT] = st_r.arm;
            v[NVC_PLOCK_BIT] = nv_r.plock;
            v[NVC_ULOCK_BIT] = nv_r.ulock;
         end
         OFF_FGAIN: v = FACTORY_GAIN[15:8];
         OFF_FGAIN + 8'h01: v = FACTORY_GAIN[7:0];
         default: begin
            // block is unreadable only while its own copy runs
            if (in_user(a) &&
                !(st_r.state == ST_COPY && !st_r.blk_param)) begin
               v = st_r.user[uidx(a)];
            end else if (in_param(a) &&
                !(st_r.state == ST_COPY && st_r.blk_param)) begin
               v = st_r.param[pidx(a)];
            end
         end
      endcase
      return v;
   endfunction

   always_comb begin
      logic idle;
      logic tgt_ok;
      logic tgt_param;
      logic tgt_locked;
      idle = (st_r.state == ST_IDLE);
      tgt_ok = in_user(req.addr) || in_param(req.addr);
      tgt_param = in_param(req.addr);
      tgt_locked = tgt_param ? nv_r.plock : nv_r.ulock;
      st_nxt = st_r;
      nv_nxt = nv_r;
      st_nxt.rd_valid = 1'b0;
      st_nxt.scmd_valid = 1'b0;

      if (upd.acr_we) begin
         st_nxt.cfg.accumulated_charge = upd.accumulated_charge;
      end
      if (upd.age_we) begin
         st_nxt.cfg.age = upd.age;
      end
      if (upd.cyc_we) begin
         st_nxt.cfg.cycle = upd.cyc;
      end

      // background save on each 4 percent step of relative capacity
      st_nxt.remaining_active_relative_capacity_step = meas.remaining_active_relative_capacity[7:REMAINING_ACTIVE_RELATIVE_CAPACITY_STEP_LSB];
      st_nxt.remaining_active_relative_capacity_seen = 1'b1;
      if (st_r.remaining_active_relative_capacity_seen && st_r.state != ST_POR &&
          meas.remaining_active_relative_capacity[7:REMAINING_ACTIVE_RELATIVE_CAPACITY_STEP_LSB] != st_r.remaining_active_relative_capacity_step) begin
         nv_nxt.accumulated_charge = st_r.cfg.accumulated_charge;
         nv_nxt.age = st_r.cfg.age;
         nv_nxt.cyc = st_r.cfg.cycle;
      end

      case (st_r.state)
         ST_POR: begin
            st_nxt.user = nv_r.user;
            st_nxt.param = nv_r.param;
            st_nxt.cfg.accumulated_charge = nv_r.accumulated_charge;
            st_nxt.cfg.age = nv_r.age;
            st_nxt.cfg.cycle = nv_r.cyc;
            st_nxt.state = ST_IDLE;
         end
         ST_COPY, ST_LOCK: begin
            st_nxt.timer = st_r.timer - TIMER_W'(1);
            if (st_r.timer == TIMER_W'(1)) begin
               st_nxt.state = ST_IDLE;
               if (st_r.state == ST_COPY) begin
                  if (st_r.blk_param) begin
                     nv_nxt.param = st_r.param;
                  end else begin
                     nv_nxt.user = st_r.user;
                  end
               end else begin
                  st_nxt.arm = 1'b0;
                  if (st_r.blk_param) begin
                     nv_nxt.plock = 1'b1;
                  end else begin
                     nv_nxt.ulock = 1'b1;
                  end
               end
            end
         end
         ST_IDLE: begin
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase

      if (st_r.state != ST_POR) begin
         if (req.start) begin
            if (st_r.arm && req.op != CMD_LOCK) begin
               st_nxt.arm = 1'b0;
            end
            case (req.op)
               CMD_COPY: begin
                  // a locked block keeps its cells untouched
                  if (idle && tgt_ok && !tgt_locked) begin
                     st_nxt.state = ST_COPY;
                     st_nxt.timer = TIMER_W'(EEC_CYC);
                     st_nxt.blk_param = tgt_param;
                  end
               end
               CMD_RECALL: begin
                  if (idle && tgt_ok) begin
                     if (tgt_param) begin
                        st_nxt.param = nv_r.param;
                     end else begin
                        st_nxt.user = nv_r.user;
                     end
                  end
               end
               CMD_LOCK: begin
                  if (st_r.arm && idle && tgt_ok) begin
                     st_nxt.state = ST_LOCK;
                     st_nxt.timer = TIMER_W'(EEC_CYC);
                     st_nxt.blk_param = tgt_param;
                  end else begin
                     st_nxt.arm = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end

         if (req.rd) begin
            st_nxt.rd_valid = 1'b1;
            if (st_r.lat_vld && req.addr == st_r.lat_addr + 8'h01) begin
               st_nxt.rdata = st_r.lat_lo;
            end else begin
               st_nxt.rdata = raw_byte(req.addr);
            end
            if (pair_hi(req.addr)) begin
               st_nxt.lat_vld = 1'b1;
               st_nxt.lat_addr = req.addr;
               st_nxt.lat_lo = raw_byte(req.addr + 8'h01);
            end
         end

         if (req.wr) begin
            case (req.addr)
               OFF_PROT: st_nxt.cfg.protection = req.wdata;
               OFF_STAT: st_nxt.cfg.status = req.wdata;
               OFF_ACR: st_nxt.cfg.accumulated_charge[15:8] = req.wdata;
               OFF_ACR + 8'h01: st_nxt.cfg.accumulated_charge[7:0] = req.wdata;
               OFF_AGE: st_nxt.cfg.age = req.wdata;
               OFF_SFR: st_nxt.cfg.special = req.wdata;
               OFF_CYC: st_nxt.cfg.cycle = req.wdata;
               OFF_NVC: st_nxt.arm = req.wdata[NVC_ARM_BIT];
               OFF_SCMD: begin
                  st_nxt.scmd_valid = 1'b1;
                  st_nxt.scmd_byte = req.wdata;
               end
               default: begin
                  // any write to either block is dropped during a copy
                  if (in_user(req.addr) && st_r.state != ST_COPY &&
                      !nv_r.ulock) begin
                     st_nxt.user[uidx(req.addr)] = req.wdata;
                  end else if (in_param(req.addr) &&
                      st_r.state != ST_COPY && !nv_r.plock) begin
                     st_nxt.param[pidx(req.addr)] = req.wdata;
                  end
               end
            endcase
         end

         if (req.done) begin
            st_nxt.lat_vld = 1'b0;
         end
      end

      if (factory_erase) begin
         nv_nxt = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0; // arm reads 0 after reset
      end else begin
         st_r <= st_nxt;
      end
   end

   // no reset: the cells model storage that outlives power cycles
   always_ff @(posedge sys_clk) begin
      nv_r <= nv_nxt;
   end

   assign rdata = st_r.rdata;
   assign rd_valid = st_r.rd_valid;
   assign cfg = st_r.cfg;
   assign param_shadow = st_r.param;
   assign busy = (st_r.state == ST_COPY) || (st_r.state == ST_LOCK);
   assign scmd_valid = st_r.scmd_valid;
   assign scmd_byte = st_r.scmd_byte;

   logic user_wr_hit;
   assign user_wr_hit = req.wr && in_user(req.addr) && st_r.state != ST_POR;

   sequence hi_read_s;
      req.rd && pair_hi(req.addr) && !req.done && st_r.state != ST_POR;
   endsequence

   sequence lo_read_s(logic [7:0] a);
      req.rd && req.addr == a + 8'h01;
   endsequence

   lock_sticky_a: assert property (@(posedge sys_clk)
      disable iff (!rst_n || factory_erase)
      nv_r.plock |=> nv_r.plock)
      else $error("parameter block lock flag fell");

   locked_write_a: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      user_wr_hit && nv_r.ulock && !(st_r.state == ST_POR)
      |=> st_r.user == $past(st_r.user))
      else $error("locked user block accepted a write");

   read_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.rd && in_user(req.addr) && st_r.state == ST_IDLE && nv_r.ulock
      && !st_r.lat_vld
      |=> rd_valid && rdata == $past(st_r.user[uidx(req.addr)]))
      else $error("locked user block read wrong data");

   busy_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_r.state == ST_COPY && req.wr
      && (in_user(req.addr) || in_param(req.addr))
      |=> st_r.param == $past(st_r.param)
      && st_r.user == $past(st_r.user))
      else $error("block write accepted during copy");

   arm_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_r.state == ST_IDLE && req.start && req.op == CMD_LOCK && !st_r.arm
      |=> !busy [*2])
      else $error("lock started without arm");

   arm_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_r.arm && req.start && req.op != CMD_LOCK && st_r.state != ST_POR
      && !(req.wr && req.addr == OFF_NVC)
      |=> !st_r.arm)
      else $error("arm survived a non-lock command");

   lock_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_r.state == ST_LOCK && st_r.timer == TIMER_W'(1)
      |=> !st_r.arm && st_r.state == ST_IDLE
      && (st_r.blk_param ? nv_r.plock : nv_r.ulock))
      else $error("lock finish did not clear arm or set flag");

   ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.rd && req.addr == OFF_NVC && st_r.state != ST_POR
      |=> rdata[NVC_BUSY_BIT] == ($past(st_r.state) == ST_COPY)
      && rdata[NVC_PLOCK_BIT] == $past(nv_r.plock)
      && rdata[NVC_ULOCK_BIT] == $past(nv_r.ulock))
      else $error("control register read mismatch");

   rsvd_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req.rd && st_r.state != ST_POR
      && req.addr inside {[8'h30:8'h5F], [8'h81:8'hAF], [8'hB2:8'hFF]}
      |=> rdata == RSVD_READ)
      else $error("reserved address did not read FFh");

   pair_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      hi_read_s ##1 (!req.done && !req.rd) ##1 lo_read_s(st_r.lat_addr)
      |=> rdata == $past(st_r.lat_lo))
      else $error("low byte of pair not taken from latch");

   copy_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_r.state == ST_COPY && st_r.timer != TIMER_W'(1)
      |=> st_r.state == ST_COPY && busy)
      else $error("copy ended before its time");

   auto_save_a: assert property (@(posedge sys_clk)
      disable iff (!rst_n || factory_erase)
      st_r.remaining_active_relative_capacity_seen && st_r.state != ST_POR
      && meas.remaining_active_relative_capacity[7:REMAINING_ACTIVE_RELATIVE_CAPACITY_STEP_LSB] != st_r.remaining_active_relative_capacity_step
      |=> nv_r.accumulated_charge == $past(st_r.cfg.accumulated_charge)
      && nv_r.age == $past(st_r.cfg.age))
      else $error("capacity step did not save charge and aging");
endmodule

//--- esm_pkg.sv
// shared constants and types for the nonvolatile shadow memory map
package esm_pkg;
   localparam int ADDR_W = 8;
   localparam int CLK_PERIOD_NS = 25;
   localparam int USER_BYTES = 16;
   localparam int PARAM_BYTES = 33;
   localparam logic [7:0] OFF_PROT = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h01;
   localparam logic [7:0] OFF_REMAINING_ACTIVE_ABSOLUTE_CAPACITY = 8'h02;
   localparam logic [7:0] OFF_REMAINING_STANDBY_ABSOLUTE_CAPACITY = 8'h04;
   localparam logic [7:0] OFF_REMAINING_ACTIVE_RELATIVE_CAPACITY = 8'h06;
   localparam logic [7:0] OFF_REMAINING_STANDBY_RELATIVE_CAPACITY = 8'h07;
   localparam logic [7:0] OFF_AVGI = 8'h08;
   localparam logic [7:0] OFF_TEMP = 8'h0A;
   localparam logic [7:0] OFF_V1 = 8'h0C;
   localparam logic [7:0] OFF_CUR = 8'h0E;
   localparam logic [7:0] OFF_ACR = 8'h10;
   localparam logic [7:0] OFF_ACRF = 8'h12;
   localparam logic [7:0] OFF_AGE = 8'h14;
   localparam logic [7:0] OFF_SFR = 8'h15;
   localparam logic [7:0] OFF_FULL = 8'h16;
   localparam logic [7:0] OFF_AE = 8'h18;
   localparam logic [7:0] OFF_SE = 8'h1A;
   localparam logic [7:0] OFF_V2 = 8'h1C;
   localparam logic [7:0] OFF_CYC = 8'h1E;
   localparam logic [7:0] OFF_NVC = 8'h1F;
   localparam logic [7:0] USER_LO = 8'h20;
   localparam logic [7:0] USER_HI = 8'h2F;
   localparam logic [7:0] PARAM_LO = 8'h60;
   localparam logic [7:0] PARAM_HI = 8'h80;
   localparam logic [7:0] OFF_FGAIN = 8'hB0;
   localparam logic [7:0] OFF_SCMD = 8'hFE;
   localparam logic [7:0] RSVD_READ = 8'hFF;
   localparam int NVC_BUSY_BIT = 7;
   localparam int NVC_ARM_BIT = 6;
   localparam int NVC_PLOCK_BIT = 1;
   localparam int NVC_ULOCK_BIT = 0;
   localparam int REMAINING_ACTIVE_RELATIVE_CAPACITY_STEP_LSB = 2;

   typedef enum logic [2:0] {
      CMD_READ = 3'b000,
      CMD_WRITE = 3'b001,
      CMD_COPY = 3'b010,
      CMD_RECALL = 3'b011,
      CMD_LOCK = 3'b100,
      CMD_OTHER = 3'b111
   } esm_cmd_t;

   typedef enum logic [1:0] {
      ST_POR = 2'b00,
      ST_IDLE = 2'b01,
      ST_COPY = 2'b10,
      ST_LOCK = 2'b11
   } esm_state_t;

   typedef struct packed {
      logic start;
      esm_cmd_t op;
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic done;
   } esm_req_t;

   typedef struct packed {
      logic [15:0] remaining_active_absolute_capacity, remaining_standby_absolute_capacity, avg_cur, temp, v1, cur, acr_frac;
      logic [15:0] full, aempty, sempty, v2;
      logic [7:0] remaining_active_relative_capacity, remaining_standby_relative_capacity;
   } esm_meas_t;

   typedef struct packed {
      logic acr_we;
      logic [15:0] accumulated_charge;
      logic age_we;
      logic [7:0] age;
      logic cyc_we;
      logic [7:0] cyc;
   } esm_upd_t;

   typedef struct packed {
      logic [7:0] protection, status, special;
      logic [15:0] accumulated_charge;
      logic [7:0] age, cycle;
   } esm_cfg_t;
endpackage

//--- tb_esm_nv_access_top.sv
// self-checking bench for the nonvolatile shadow memory map
`timescale 1ns/100ps
module tb_esm_nv_access_top import esm_pkg::*;;
   localparam logic [15:0] GAIN = 16'h0A5C;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic factory_erase = 1'b1;
   esm_req_t req;
   esm_meas_t meas = '0;
   esm_upd_t upd = '0;
   logic [7:0] rdata, scmd_byte;
   logic rd_valid, busy, scmd_valid;
   esm_cfg_t cfg;
   logic [PARAM_BYTES-1:0][7:0] pshadow;
   logic [7:0] rsvd [5] = '{8'h30, 8'h5F, 8'h81, 8'hB2, 8'hFF};
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #12.5 sys_clk = ~sys_clk;

   esm_nv_access_top #(.EEC_TIME_NS(250), .FACTORY_GAIN(GAIN))
      esm_nv_access_top_i (.sys_clk(sys_clk), .rstn(rstn), .req(req),
      .meas(meas), .upd(upd), .factory_erase(factory_erase),
      .rdata(rdata), .rd_valid(rd_valid), .cfg(cfg),
      .param_shadow(pshadow), .busy(busy), .scmd_valid(scmd_valid),
      .scmd_byte(scmd_byte));

   esm_host_model esm_host_model_i (.sys_clk(sys_clk), .rdata(rdata),
      .rd_valid(rd_valid), .req(req));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rc(logic [7:0] a, logic [7:0] exp, string nm);
      logic [7:0] d;
      esm_host_model_i.rd(a, d);
      chk(nm, {8'h00, d}, {8'h00, exp});
   endtask

   // lets the launching edge land before polling, bounded wait
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (2) @(posedge sys_clk);
      while (busy !== 1'b0 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      chk("busy", {15'h0000, busy}, 16'h0000);
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         end_sim();
      end
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      // cells have no reset, so erase them and reload both shadows
      repeat (6) @(posedge sys_clk);
      factory_erase <= 1'b0;
      repeat (2) @(posedge sys_clk);
      esm_host_model_i.cmd(CMD_RECALL, USER_LO);
      esm_host_model_i.cmd(CMD_RECALL, PARAM_LO);
      rc(OFF_NVC, 8'h00, "nvc reset");
      foreach (rsvd[i]) rc(rsvd[i], RSVD_READ, "reserved");
      esm_host_model_i.wr(OFF_FGAIN, 8'h00);
      rc(OFF_FGAIN, GAIN[15:8], "gain hi");
      rc(OFF_FGAIN + 8'h01, GAIN[7:0], "gain lo");
      meas.cur <= 16'h1234;
      rc(OFF_CUR, 8'h12, "cur hi");
      meas.cur <= 16'h5678;
      rc(OFF_CUR + 8'h01, 8'h34, "cur lo latched");
      esm_host_model_i.done();
      rc(OFF_CUR + 8'h01, 8'h78, "cur lo live");
      esm_host_model_i.wr(OFF_PROT, 8'h5A);
      @(negedge sys_clk);
      chk("cfg prot", {8'h00, cfg.protection}, 16'h005A);
      esm_host_model_i.wr(OFF_SCMD, 8'hC3);
      @(negedge sys_clk);
      chk("scmd", {7'h00, scmd_valid, scmd_byte}, 16'h01C3);
      esm_host_model_i.wr(8'h61, 8'h3C);
      @(negedge sys_clk);
      chk("param 61", {8'h00, pshadow[1]}, 16'h003C);
      esm_host_model_i.wr(USER_LO, 8'hA5);
      esm_host_model_i.cmd(CMD_COPY, USER_LO);
      rc(OFF_NVC, 8'h80, "nvc copying");
      esm_host_model_i.wr(USER_LO + 8'h01, 8'h77);
      rc(USER_LO, 8'hFF, "block in copy");
      wait_idle();
      rc(USER_LO + 8'h01, 8'h00, "write in copy");
      esm_host_model_i.wr(USER_LO, 8'h00);
      esm_host_model_i.cmd(CMD_RECALL, USER_LO);
      rc(USER_LO, 8'hA5, "recall");
      esm_host_model_i.cmd(CMD_LOCK, USER_LO);
      wait_idle();
      rc(OFF_NVC, 8'h00, "lock unarmed");
      esm_host_model_i.wr(OFF_NVC, 8'h40);
      rc(OFF_NVC, 8'h40, "armed");
      esm_host_model_i.cmd(CMD_OTHER, 8'h00);
      rc(OFF_NVC, 8'h00, "arm dropped");
      esm_host_model_i.wr(OFF_NVC, 8'h40);
      esm_host_model_i.cmd(CMD_LOCK, USER_LO);
      wait_idle();
      rc(OFF_NVC, 8'h01, "user locked");
      esm_host_model_i.wr(USER_LO, 8'h3C);
      rc(USER_LO, 8'hA5, "locked write");
      esm_host_model_i.cmd(CMD_COPY, USER_LO);
      rc(OFF_NVC, 8'h01, "locked copy");
      esm_host_model_i.wr(OFF_NVC, 8'h40);
      esm_host_model_i.cmd(CMD_LOCK, PARAM_LO);
      wait_idle();
      rc(OFF_NVC, 8'h03, "param locked");
      esm_host_model_i.wr(OFF_NVC, 8'h00);
      rc(OFF_NVC, 8'h03, "no unlock");
      esm_host_model_i.wr(OFF_ACR, 8'h12);
      esm_host_model_i.wr(OFF_ACR + 8'h01, 8'h34);
      @(posedge sys_clk);
      upd.age_we <= 1'b1;
      upd.age <= 8'h3C;
      @(posedge sys_clk);
      upd.age_we <= 1'b0;
      // one 4 percent step crossed: charge and aging go to the cells
      meas.remaining_active_relative_capacity <= 8'h04;
      repeat (2) @(posedge sys_clk);
      chk("cfg age", {8'h00, cfg.age}, 16'h003C);
      // second reset: cells keep their content, shadows reload from them
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rc(OFF_ACR, 8'h12, "acr saved");
      rc(OFF_ACR + 8'h01, 8'h34, "acr lo saved");
      rc(OFF_AGE, 8'h3C, "age saved");
      rc(OFF_NVC, 8'h03, "locks kept");
      rc(USER_LO, 8'hA5, "user reloaded");
      rc(8'h61, 8'h00, "param not copied");
      end_sim();
   end
endmodule
